// >>> include/fcp_defs.svh
// constants of the flash command and protection block
// assumes a 20-bit flash address space and 16-bit flash bus cycles
`ifndef FCP_DEFS_SVH
`define FCP_DEFS_SVH
`define FCP_CMD_PROG    8'h40
`define FCP_CMD_LOCK    8'h77
`define FCP_CMD_CONF    8'hD0
`define FCP_ID_A0       20'hFFFDF
`define FCP_ID_A1       20'hFFFE3
`define FCP_ID_A2       20'hFFFEB
`define FCP_ID_A3       20'hFFFEF
`define FCP_ID_A4       20'hFFFF3
`define FCP_ID_A5       20'hFFFF7
`define FCP_ID_A6       20'hFFFFB
`define FCP_ROM_CODE_PROTECT_A     20'hFFFFF
`define FCP_IDX_LOCK    16'h0000
`define FCP_IDX_STAT    16'h0001
`define FCP_IDX_KLO     16'h0002
`define FCP_IDX_KHI     16'h0003
`define FCP_IDX_ILO     16'h0004
`define FCP_IDX_IHI     16'h0005
`define FCP_IDX_ROM_CODE_PROTECT   16'hFFFF
`define FCP_ERASED      8'hFF
`define FCP_OPEN_HI     7
`define FCP_OPEN_LO     6
`define FCP_OPEN_VAL    2'h3
`define FCP_ST_STATE_LO 0
`define FCP_ST_BUSY     2
`define FCP_ST_DENY     3
`define FCP_ST_ABORT    4
`define FCP_ST_VERR     5
`define FCP_RESP_OK     2'h0
`define FCP_RESP_ERR    2'h2
`endif

// >>> include/fcp_pkg.sv
// types shared by the flash command and protection block
// assumes fcp_defs.svh for all numeric constants
package fcp_pkg;
  typedef enum logic [1:0] {
    FCP_IDLE  = 2'h0,
    FCP_PROG1 = 2'h1,
    FCP_BUSY  = 2'h3,
    FCP_LOCK1 = 2'h2
  } fcp_state_e;
  typedef logic [19:0] fcp_addr_t;
  typedef logic [15:0] fcp_word_t;
  typedef logic [7:0]  fcp_byte_t;
endpackage : fcp_pkg

// >>> logic/fcp_seq.sv
// two-cycle command decoder: program and lock-bit program
// assumes write cycles already gated by protection, one per clock
`timescale 1ns/1ps
`include "fcp_defs.svh"
module fcp_seq #(
  parameter int BLOCK_BITS = 16,
  parameter int NUM_BLOCKS = 16,
  parameter int LW         = 4
) (
  // clock and reset
  input  logic               clk,
  input  logic               rst,
  // host write cycles
  input  logic               wr_en,
  input  fcp_pkg::fcp_addr_t wr_addr,
  input  fcp_pkg::fcp_word_t wr_data,
  // flash macro answer
  input  logic               fl_done,
  input  fcp_pkg::fcp_word_t fl_rdata,
  // results
  output logic               prog_req,
  output fcp_pkg::fcp_addr_t prog_addr,
  output fcp_pkg::fcp_word_t prog_data,
  output logic               lock_clr,
  output logic [LW-1:0]      lock_idx,
  output logic               done_ok,
  output logic               verify_err,
  output logic               abort,
  output fcp_pkg::fcp_state_e state
);
  import fcp_pkg::*;
  localparam int BW = 20 - BLOCK_BITS;
  localparam logic [BW-1:0] MAXB = BW'(NUM_BLOCKS - 1);

  fcp_state_e state_ff, nxt_state;
  fcp_addr_t  first_ff, nxt_first, paddr_ff, nxt_paddr;
  fcp_word_t  pdata_ff, nxt_pdata;
  logic [LW-1:0] lidx_ff, nxt_lidx;
  logic req_ff, nxt_req, lclr_ff, nxt_lclr, ok_ff, nxt_ok;
  logic verr_ff, nxt_verr, abort_ff, nxt_abort;
  logic [BW-1:0] blk;
  logic is_top;

  assign blk    = wr_addr[19:BLOCK_BITS];
  assign is_top = (&wr_addr[BLOCK_BITS-1:1]) && !wr_addr[0] && (blk <= MAXB);

  always_comb begin
    nxt_state = state_ff;
    nxt_first = first_ff;
    nxt_paddr = paddr_ff;
    nxt_pdata = pdata_ff;
    nxt_lidx  = lidx_ff;
    nxt_req   = 1'b0;
    nxt_lclr  = 1'b0;
    nxt_ok    = 1'b0;
    nxt_verr  = 1'b0;
    nxt_abort = 1'b0;
    case (state_ff)
      FCP_IDLE: begin
        if (wr_en && wr_data[7:0] == `FCP_CMD_PROG) begin
          nxt_state = FCP_PROG1;
          nxt_first = wr_addr;
        end else if (wr_en && wr_data[7:0] == `FCP_CMD_LOCK) begin
          nxt_state = FCP_LOCK1;
          nxt_first = wr_addr;
        end
      end
      FCP_PROG1: begin
        if (wr_en && wr_addr == first_ff && !wr_addr[0]) begin
          nxt_state = FCP_BUSY;
          nxt_req   = 1'b1;
          nxt_paddr = wr_addr;
          nxt_pdata = wr_data;
        end else if (wr_en) begin
          nxt_state = FCP_IDLE;
          nxt_abort = 1'b1;
        end
      end
      FCP_LOCK1: begin
        if (wr_en) begin
          nxt_state = FCP_IDLE;
          if (wr_addr == first_ff && is_top && wr_data[7:0] == `FCP_CMD_CONF) begin
            nxt_lclr = 1'b1;
            nxt_lidx = blk[LW-1:0];
          end else begin
            nxt_abort = 1'b1;
          end
        end
      end
      FCP_BUSY: begin
        // host writes are ignored until the macro reports done
        if (fl_done) begin
          nxt_state = FCP_IDLE;
          nxt_ok    = (fl_rdata == pdata_ff);
          nxt_verr  = (fl_rdata != pdata_ff);
        end
      end
      default: nxt_state = FCP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= FCP_IDLE;
      first_ff <= '0;
      paddr_ff <= '0;
      pdata_ff <= '0;
      lidx_ff  <= '0;
      req_ff   <= 1'b0;
      lclr_ff  <= 1'b0;
      ok_ff    <= 1'b0;
      verr_ff  <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      first_ff <= nxt_first;
      paddr_ff <= nxt_paddr;
      pdata_ff <= nxt_pdata;
      lidx_ff  <= nxt_lidx;
      req_ff   <= nxt_req;
      lclr_ff  <= nxt_lclr;
      ok_ff    <= nxt_ok;
      verr_ff  <= nxt_verr;
      abort_ff <= nxt_abort;
    end
  end

  assign prog_req   = req_ff;
  assign prog_addr  = paddr_ff;
  assign prog_data  = pdata_ff;
  assign lock_clr   = lclr_ff;
  assign lock_idx   = lidx_ff;
  assign done_ok    = ok_ff;
  assign verify_err = verr_ff;
  assign abort      = abort_ff;
  assign state      = state_ff;

  a_prog_start: assert property (@(posedge clk) disable iff (rst)
    (state_ff == FCP_PROG1 && wr_en && wr_addr == first_ff && !wr_addr[0])
    |=> req_ff && state_ff == FCP_BUSY && paddr_ff == $past(wr_addr))
    else $error("program not started by matching second write");
  a_seq_abort: assert property (@(posedge clk) disable iff (rst)
    (state_ff == FCP_PROG1 && wr_en && wr_addr != first_ff)
    |=> abort_ff && !req_ff && state_ff == FCP_IDLE)
    else $error("mismatched program sequence not abandoned");
  a_lock_bad: assert property (@(posedge clk) disable iff (rst)
    (state_ff == FCP_LOCK1 && wr_en && wr_data[7:0] != `FCP_CMD_CONF)
    |=> !lclr_ff ##1 !lclr_ff)
    else $error("lock bit cleared without confirm code");
  a_verify_cmp: assert property (@(posedge clk) disable iff (rst)
    (state_ff == FCP_BUSY && fl_done && fl_rdata != pdata_ff)
    |=> verr_ff && !ok_ff)
    else $error("verify mismatch not reported");
endmodule : fcp_seq

// >>> logic/fcp_top.sv
// flash command and protection block with an AXI4-Lite register slave
// assumes flash bus cycles and mode straps synchronous to MCLK,
// and a flash macro that pulses FL_DONE after PROG_REQ with readback data
//
// Behaviour
// - seven ID bytes are held and a key mismatch blocks flash access in serial mode.
// - the protect-control byte at the top address blocks parallel-mode access when wrong.
// - the ID and protect-control bytes double as high bytes of the fixed vectors.
// - a program code write then a data write to the same even address starts a program with verify.
// - a lock code write then a confirm write to a block top clears its lock bit.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fcp_defs.svh"
module fcp_top #(
  parameter int AW         = 18,
  parameter int BLOCK_BITS = 16,
  parameter int NUM_BLOCKS = 16
) (
  // clock and reset
  input  logic                MCLK,
  input  logic                RESET,
  // axi4-lite write
  input  logic                AWVALID,
  output logic                AWREADY,
  input  logic [AW-1:0]       AWADDR,
  input  logic                WVALID,
  output logic                WREADY,
  input  logic [31:0]         WDATA,
  input  logic [3:0]          WSTRB,
  output logic                BVALID,
  input  logic                BREADY,
  output logic [1:0]          BRESP,
  // axi4-lite read
  input  logic                ARVALID,
  output logic                ARREADY,
  input  logic [AW-1:0]       ARADDR,
  output logic                RVALID,
  input  logic                RREADY,
  output logic [31:0]         RDATA,
  output logic [1:0]          RRESP,
  // flash bus cycles and modes
  input  logic                FBUS_WE,
  input  fcp_pkg::fcp_addr_t  FBUS_ADDR,
  input  fcp_pkg::fcp_word_t  FBUS_WDATA,
  input  logic                MODE_SERIAL,
  input  logic                MODE_PARALLEL,
  input  logic [2:0]          VEC_SEL,
  // flash macro
  input  logic                FL_DONE,
  input  fcp_pkg::fcp_word_t  FL_RDATA,
  output logic                PROG_REQ,
  output fcp_pkg::fcp_addr_t  PROG_ADDR,
  output fcp_pkg::fcp_word_t  PROG_DATA,
  // protection state
  output logic                ACCESS_DENY,
  output logic [NUM_BLOCKS-1:0] LOCK_BITS,
  output fcp_pkg::fcp_byte_t  VEC_HI
);
  import fcp_pkg::*;
  localparam int LW = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;
  // entry 7 is the protect-control byte, 0..6 the id bytes
  localparam fcp_addr_t SH_A [8] = '{`FCP_ID_A0, `FCP_ID_A1, `FCP_ID_A2,
    `FCP_ID_A3, `FCP_ID_A4, `FCP_ID_A5, `FCP_ID_A6, `FCP_ROM_CODE_PROTECT_A};

  // write channel state
  logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff, nxt_bresp;
  logic [15:0] aw_idx_ff, nxt_aw_idx;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0]  wstrb_ff, nxt_wstrb;
  logic do_wr;
  // read channel state
  logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata, rd_word;
  logic [15:0] ar_idx;
  logic rd_err;
  // protection and status state
  logic [7:0][7:0] shadow_ff, nxt_shadow;
  logic [6:0][7:0] key_ff, nxt_key;
  logic [NUM_BLOCKS-1:0] lock_ff, nxt_lock;
  logic verr_st_ff, nxt_verr_st, abort_st_ff, nxt_abort_st;
  logic deny_ff, nxt_deny;
  fcp_byte_t vec_ff, nxt_vec;
  fcp_byte_t rom_code_protect_w;
  logic [6:0] key_eq;
  logic serial_bad, par_bad, seq_we;
  logic [31:0] stat_word;
  // sequencer outputs
  logic lock_clr, done_ok, verify_err, abort_ev;
  logic [LW-1:0] lock_idx;
  fcp_state_e seq_state;

  // key bytes compared against the stored id bytes
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_key
      assign key_eq[g] = (key_ff[g] == shadow_ff[g]);
    end
  endgenerate

  assign rom_code_protect_w    = shadow_ff[7];
  assign serial_bad = MODE_SERIAL && (key_eq != 7'h7F);
  assign par_bad    = MODE_PARALLEL &&
    (rom_code_protect_w[`FCP_OPEN_HI:`FCP_OPEN_LO] != `FCP_OPEN_VAL);
  // gate combinationally so a denied cycle never reaches the decoder
  assign seq_we = FBUS_WE && !serial_bad && !par_bad;

  fcp_seq #(
    .BLOCK_BITS (BLOCK_BITS),
    .NUM_BLOCKS (NUM_BLOCKS),
    .LW         (LW)
  ) u_seq (
    .clk        (MCLK),
    .rst        (RESET),
    .wr_en      (seq_we),
    .wr_addr    (FBUS_ADDR),
    .wr_data    (FBUS_WDATA),
    .fl_done    (FL_DONE),
    .fl_rdata   (FL_RDATA),
    .prog_req   (PROG_REQ),
    .prog_addr  (PROG_ADDR),
    .prog_data  (PROG_DATA),
    .lock_clr   (lock_clr),
    .lock_idx   (lock_idx),
    .done_ok    (done_ok),
    .verify_err (verify_err),
    .abort      (abort_ev),
    .state      (seq_state)
  );

  // address and data may arrive in either order; answer once both held
  assign do_wr = aw_held_ff && w_held_ff && !bvalid_ff;

  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held  = w_held_ff;
    nxt_aw_idx  = aw_idx_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (AWVALID && awready_ff) begin
      nxt_aw_held = 1'b1;
      nxt_aw_idx  = AWADDR[17:2];
    end
    if (WVALID && wready_ff) begin
      nxt_w_held = 1'b1;
      nxt_wdata  = WDATA;
      nxt_wstrb  = WSTRB;
    end
    if (bvalid_ff && BREADY) begin
      nxt_bvalid = 1'b0;
    end
    if (do_wr) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      if (aw_idx_ff == `FCP_IDX_LOCK || aw_idx_ff == `FCP_IDX_STAT ||
          aw_idx_ff == `FCP_IDX_KLO || aw_idx_ff == `FCP_IDX_KHI ||
          aw_idx_ff == `FCP_IDX_ILO || aw_idx_ff == `FCP_IDX_IHI ||
          aw_idx_ff == `FCP_IDX_ROM_CODE_PROTECT) begin
        nxt_bresp = `FCP_RESP_OK;
      end else begin
        nxt_bresp = `FCP_RESP_ERR;
      end
    end
    nxt_awready = !nxt_aw_held;
    nxt_wready  = !nxt_w_held;
  end

  // register read mux
  assign ar_idx = ARADDR[17:2];
  always_comb begin
    stat_word = 32'h0;
    stat_word[`FCP_ST_STATE_LO +: 2] = seq_state;
    stat_word[`FCP_ST_BUSY]  = (seq_state == FCP_BUSY);
    stat_word[`FCP_ST_DENY]  = deny_ff;
    stat_word[`FCP_ST_ABORT] = abort_st_ff;
    stat_word[`FCP_ST_VERR]  = verr_st_ff;
    rd_err  = 1'b0;
    rd_word = 32'h0;
    if (ar_idx == `FCP_IDX_LOCK) begin
      rd_word[NUM_BLOCKS-1:0] = lock_ff;
    end else if (ar_idx == `FCP_IDX_STAT) begin
      rd_word = stat_word;
    end else if (ar_idx == `FCP_IDX_KLO) begin
      rd_word = key_ff[3:0];
    end else if (ar_idx == `FCP_IDX_KHI) begin
      rd_word[23:0] = key_ff[6:4];
    end else if (ar_idx == `FCP_IDX_ILO) begin
      rd_word = shadow_ff[3:0];
    end else if (ar_idx == `FCP_IDX_IHI) begin
      rd_word[23:0] = shadow_ff[6:4];
    end else if (ar_idx == `FCP_IDX_ROM_CODE_PROTECT) begin
      rd_word[7:0] = rom_code_protect_w;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (rvalid_ff && RREADY) begin
      nxt_rvalid = 1'b0;
    end
    if (ARVALID && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = rd_word;
      nxt_rresp  = rd_err ? `FCP_RESP_ERR : `FCP_RESP_OK;
    end
    nxt_arready = !nxt_rvalid;
  end

  // key, stored bytes, lock bits, sticky status
  always_comb begin
    nxt_key    = key_ff;
    nxt_shadow = shadow_ff;
    nxt_lock   = lock_ff;
    for (int b = 0; b < 7; b++) begin
      if (do_wr && wstrb_ff[b % 4] &&
          aw_idx_ff == ((b < 4) ? `FCP_IDX_KLO : `FCP_IDX_KHI)) begin
        nxt_key[b] = wdata_ff[8 * (b % 4) +: 8];
      end
    end
    if (do_wr && wstrb_ff[0] && aw_idx_ff == `FCP_IDX_ROM_CODE_PROTECT) begin
      nxt_shadow[7] = wdata_ff[7:0];
    end
    // a verified word whose high byte lands on a vector location updates it
    for (int e = 0; e < 8; e++) begin
      if (done_ok && PROG_ADDR == {SH_A[e][19:1], 1'b0}) begin
        nxt_shadow[e] = PROG_DATA[15:8];
      end
    end
    if (lock_clr) begin
      nxt_lock[lock_idx] = 1'b0;
    end
    // hardware set wins over a same-cycle write-one-to-clear
    nxt_verr_st  = verr_st_ff;
    nxt_abort_st = abort_st_ff;
    if (do_wr && wstrb_ff[0] && aw_idx_ff == `FCP_IDX_STAT) begin
      nxt_verr_st  = verr_st_ff && !wdata_ff[`FCP_ST_VERR];
      nxt_abort_st = abort_st_ff && !wdata_ff[`FCP_ST_ABORT];
    end
    nxt_verr_st  = nxt_verr_st || verify_err;
    nxt_abort_st = nxt_abort_st || abort_ev;
    nxt_deny = serial_bad || par_bad;
    nxt_vec  = shadow_ff[VEC_SEL];
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      aw_held_ff  <= 1'b0;
      w_held_ff   <= 1'b0;
      awready_ff  <= 1'b0;
      wready_ff   <= 1'b0;
      bvalid_ff   <= 1'b0;
      bresp_ff    <= `FCP_RESP_OK;
      aw_idx_ff   <= 16'h0;
      wdata_ff    <= 32'h0;
      wstrb_ff    <= 4'h0;
      arready_ff  <= 1'b0;
      rvalid_ff   <= 1'b0;
      rdata_ff    <= 32'h0;
      rresp_ff    <= `FCP_RESP_OK;
      shadow_ff   <= {8{`FCP_ERASED}};
      key_ff      <= {7{`FCP_ERASED}};
      lock_ff     <= '1;
      verr_st_ff  <= 1'b0;
      abort_st_ff <= 1'b0;
      deny_ff     <= 1'b0;
      vec_ff      <= 8'h0;
    end else begin
      aw_held_ff  <= nxt_aw_held;
      w_held_ff   <= nxt_w_held;
      awready_ff  <= nxt_awready;
      wready_ff   <= nxt_wready;
      bvalid_ff   <= nxt_bvalid;
      bresp_ff    <= nxt_bresp;
      aw_idx_ff   <= nxt_aw_idx;
      wdata_ff    <= nxt_wdata;
      wstrb_ff    <= nxt_wstrb;
      arready_ff  <= nxt_arready;
      rvalid_ff   <= nxt_rvalid;
      rdata_ff    <= nxt_rdata;
      rresp_ff    <= nxt_rresp;
      shadow_ff   <= nxt_shadow;
      key_ff      <= nxt_key;
      lock_ff     <= nxt_lock;
      verr_st_ff  <= nxt_verr_st;
      abort_st_ff <= nxt_abort_st;
      deny_ff     <= nxt_deny;
      vec_ff      <= nxt_vec;
    end
  end

  assign AWREADY     = awready_ff;
  assign WREADY      = wready_ff;
  assign BVALID      = bvalid_ff;
  assign BRESP       = bresp_ff;
  assign ARREADY     = arready_ff;
  assign RVALID      = rvalid_ff;
  assign RDATA       = rdata_ff;
  assign RRESP       = rresp_ff;
  assign ACCESS_DENY = deny_ff;
  assign LOCK_BITS   = lock_ff;
  assign VEC_HI      = vec_ff;

  a_serial_deny: assert property (@(posedge MCLK) disable iff (RESET)
    (MODE_SERIAL && key_eq != 7'h7F) |=> ACCESS_DENY)
    else $error("serial access not denied on key mismatch");
  a_serial_gate: assert property (@(posedge MCLK) disable iff (RESET)
    (MODE_SERIAL && key_eq != 7'h7F && FBUS_WE)
    |=> !PROG_REQ)
    else $error("denied write started a program");
  a_cpu_open: assert property (@(posedge MCLK) disable iff (RESET)
    (!MODE_SERIAL && !MODE_PARALLEL) |=> !ACCESS_DENY)
    else $error("access denied outside programming modes");
  a_par_deny: assert property (@(posedge MCLK) disable iff (RESET)
    (MODE_PARALLEL && rom_code_protect_w[`FCP_OPEN_HI:`FCP_OPEN_LO] != `FCP_OPEN_VAL)
    |=> ACCESS_DENY)
    else $error("parallel access not denied on bad protect byte");
  a_vec_byte: assert property (@(posedge MCLK) disable iff (RESET)
    (VEC_SEL == 3'h7) |=> (VEC_HI == $past(rom_code_protect_w)))
    else $error("vector high byte differs from protect byte");
  a_rom_code_protect_prog: assert property (@(posedge MCLK) disable iff (RESET)
    (done_ok && PROG_ADDR == 20'hFFFFE) |=> (rom_code_protect_w == $past(PROG_DATA[15:8])))
    else $error("program of top word did not update protect byte");
  a_lock_clear: assert property (@(posedge MCLK) disable iff (RESET)
    lock_clr |=> !LOCK_BITS[$past(lock_idx)])
    else $error("lock bit not cleared");
endmodule : fcp_top

// >>> tb/fcp_flash_model.sv
// behavioural flash array: answers each program request with a done pulse
// assumes program requests are one-cycle pulses synchronous to clk
`timescale 1ns/1ps
module fcp_flash_model #(
  parameter int DELAY = 3
) (
  // clock and reset
  input  logic               clk,
  input  logic               rst,
  // request side
  input  logic               prog_req,
  input  fcp_pkg::fcp_word_t prog_data,
  input  logic               bad_verify,
  // answer side
  output logic               fl_done,
  output fcp_pkg::fcp_word_t fl_rdata
);
  import fcp_pkg::*;
  int cnt_ff = 0;
  initial begin
    fl_done  = 1'b0;
    fl_rdata = 16'h0000;
  end
  always @(posedge clk) begin
    fl_done <= 1'b0;
    if (!rst && cnt_ff == 1) begin
      fl_done  <= 1'b1;
      fl_rdata <= bad_verify ? ~prog_data : prog_data;
    end else begin
      // readback is only valid with done; toggle so a stale word never matches
      fl_rdata <= ~fl_rdata;
    end
    if (rst) cnt_ff <= 0;
    else if (prog_req) cnt_ff <= DELAY;
    else if (cnt_ff > 0) cnt_ff <= cnt_ff - 1;
  end
endmodule : fcp_flash_model

// >>> tb/flash_cmd_and_protect_test.sv
// self-checking bench: axi4-lite register access and flash bus commands
// assumes fcp_top with default parameters and a behavioural flash macro
`timescale 1ns/1ps
`include "fcp_defs.svh"
module flash_cmd_and_protect_test;
  import fcp_pkg::*;
  logic        MCLK, RESET, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, FBUS_WE, MODE_SERIAL, MODE_PARALLEL;
  logic        FL_DONE, PROG_REQ, ACCESS_DENY, bad;
  logic [17:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rsp;
  logic [2:0]  VEC_SEL;
  logic [15:0] LOCK_BITS;
  fcp_addr_t   FBUS_ADDR, PROG_ADDR;
  fcp_word_t   FBUS_WDATA, FL_RDATA, PROG_DATA;
  fcp_byte_t   VEC_HI;
  int          mismatches = 0;
  int          checks = 0;
  int          preqs = 0;

  fcp_top u_dut (.MCLK(MCLK), .RESET(RESET), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .FBUS_WE(FBUS_WE), .FBUS_ADDR(FBUS_ADDR), .FBUS_WDATA(FBUS_WDATA),
    .MODE_SERIAL(MODE_SERIAL), .MODE_PARALLEL(MODE_PARALLEL), .VEC_SEL(VEC_SEL),
    .FL_DONE(FL_DONE), .FL_RDATA(FL_RDATA), .PROG_REQ(PROG_REQ), .PROG_ADDR(PROG_ADDR),
    .PROG_DATA(PROG_DATA), .ACCESS_DENY(ACCESS_DENY), .LOCK_BITS(LOCK_BITS), .VEC_HI(VEC_HI));

  fcp_flash_model u_flash (.clk(MCLK), .rst(RESET), .prog_req(PROG_REQ),
    .prog_data(PROG_DATA), .bad_verify(bad), .fl_done(FL_DONE), .fl_rdata(FL_RDATA));

  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  always @(posedge MCLK) begin
    if (PROG_REQ === 1'b1) preqs <= preqs + 1;
  end

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic axi_wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge MCLK);
    AWVALID <= 1'b1;
    AWADDR  <= a;
    WVALID  <= 1'b1;
    WDATA   <= d;
    BREADY  <= 1'b1;
    // the loop test sees pre-edge values, so it runs one edge past the response
    do begin
      @(posedge MCLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BREADY && BVALID) begin
        BREADY <= 1'b0;
        cmp("bresp", {30'h0, er}, {30'h0, BRESP});
      end
    end while (AWVALID || WVALID || BREADY);
  endtask : axi_wr

  task automatic axi_rd(input logic [17:0] a);
    @(posedge MCLK);
    ARVALID <= 1'b1;
    ARADDR  <= a;
    RREADY  <= 1'b1;
    do begin
      @(posedge MCLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RREADY && RVALID) begin
        RREADY <= 1'b0;
        rd = RDATA;
        rsp = RRESP;
      end
    end while (ARVALID || RREADY);
  endtask : axi_rd

  task automatic reg_chk(input string what, input logic [17:0] a, input logic [31:0] exp);
    axi_rd(a);
    cmp(what, exp, rd);
    cmp("rresp", 32'h0, {30'h0, rsp});
  endtask : reg_chk

  // two back-to-back flash bus writes; bus shows inverted junk when released
  task automatic fbus2(input fcp_addr_t a1, input fcp_word_t d1, input fcp_addr_t a2,
                       input fcp_word_t d2);
    @(posedge MCLK);
    FBUS_WE <= 1'b1; FBUS_ADDR <= a1; FBUS_WDATA <= d1;
    @(posedge MCLK);
    FBUS_ADDR <= a2; FBUS_WDATA <= d2;
    @(posedge MCLK);
    FBUS_WE <= 1'b0; FBUS_ADDR <= ~a2; FBUS_WDATA <= ~d2;
    repeat (10) @(posedge MCLK);
  endtask : fbus2

  initial begin
    #800000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    RESET = 1'b1; AWVALID = 1'b0; WVALID = 1'b0; BREADY = 1'b0; ARVALID = 1'b0;
    RREADY = 1'b0; AWADDR = 18'h00000; ARADDR = 18'h00000; WDATA = 32'h0;
    WSTRB = 4'hF; FBUS_WE = 1'b0; FBUS_ADDR = 20'h00000; FBUS_WDATA = 16'h0000;
    MODE_SERIAL = 1'b0; MODE_PARALLEL = 1'b0; VEC_SEL = 3'h0; bad = 1'b0;
    repeat (12) @(posedge MCLK);
    RESET <= 1'b0;
    repeat (2) @(posedge MCLK);
    reg_chk("lock reset", 18'h00000, 32'h0000FFFF);
    reg_chk("protect reset", 18'h3FFFC, 32'h000000FF);
    reg_chk("id lo reset", 18'h00010, 32'hFFFFFFFF);
    axi_rd(18'h00020);
    cmp("unmapped rresp", 32'h2, {30'h0, rsp});
    axi_wr(18'h00020, 32'h1, 2'h2);
    // program with same even address in both cycles
    fbus2(20'h10000, 16'hAA40, 20'h10000, 16'h1234);
    cmp("prog count", 32'd1, preqs);
    cmp("prog addr", 32'h10000, {12'h0, PROG_ADDR});
    cmp("prog data", 32'h1234, {16'h0, PROG_DATA});
    // program into an id byte slot, then check it as vector high byte
    fbus2(20'hFFFDE, 16'h0040, 20'hFFFDE, 16'hAB00);
    reg_chk("id byte 0", 18'h00010, 32'hFFFFFFAB);
    VEC_SEL <= 3'h0;
    repeat (3) @(posedge MCLK);
    cmp("vector high", 32'hAB, {24'h0, VEC_HI});
    // serial mode with stale key is refused, then opened by the key
    MODE_SERIAL <= 1'b1;
    repeat (3) @(posedge MCLK);
    cmp("serial deny", 32'h1, {31'h0, ACCESS_DENY});
    fbus2(20'h30000, 16'h0040, 20'h30000, 16'h0101);
    cmp("denied prog", 32'd2, preqs);
    axi_wr(18'h00008, 32'hFFFFFFAB, 2'h0);
    repeat (3) @(posedge MCLK);
    cmp("serial open", 32'h0, {31'h0, ACCESS_DENY});
    MODE_SERIAL <= 1'b0;
    // parallel mode with a closed protect byte
    axi_wr(18'h3FFFC, 32'h0000003F, 2'h0);
    MODE_PARALLEL <= 1'b1;
    repeat (3) @(posedge MCLK);
    cmp("parallel deny", 32'h1, {31'h0, ACCESS_DENY});
    fbus2(20'h30000, 16'h0040, 20'h30000, 16'h0202);
    cmp("parallel prog", 32'd2, preqs);
    axi_wr(18'h3FFFC, 32'h000000FF, 2'h0);
    repeat (3) @(posedge MCLK);
    cmp("parallel open", 32'h0, {31'h0, ACCESS_DENY});
    MODE_PARALLEL <= 1'b0;
    // lock bit clear on block 2, then a bad confirm on block 3
    fbus2(20'h2FFFE, 16'h0077, 20'h2FFFE, 16'h00D0);
    cmp("lock bits", 32'hFFFB, {16'h0, LOCK_BITS});
    fbus2(20'h3FFFE, 16'h0077, 20'h3FFFE, 16'h00D1);
    reg_chk("lock reg", 18'h00000, 32'h0000FFFB);
    // program abandoned on address change
    fbus2(20'h50000, 16'h0040, 20'h50002, 16'h7777);
    cmp("abort no prog", 32'd2, preqs);
    axi_rd(18'h00004);
    cmp("abort flag", 32'h10, rd & 32'h33);
    // readback mismatch flags a verify error
    bad <= 1'b1;
    fbus2(20'h40000, 16'h0040, 20'h40000, 16'h5555);
    bad <= 1'b0;
    axi_rd(18'h00004);
    cmp("verify flag", 32'h30, rd & 32'h33);
    axi_wr(18'h00004, 32'h00000030, 2'h0);
    axi_rd(18'h00004);
    cmp("flags cleared", 32'h0, rd & 32'h37);
    // program the top word: its high byte is the protect byte and vector 7
    fbus2(20'hFFFFE, 16'h0040, 20'hFFFFE, 16'hC000);
    reg_chk("protect by program", 18'h3FFFC, 32'h000000C0);
    VEC_SEL <= 3'h7;
    repeat (3) @(posedge MCLK);
    cmp("vector protect", 32'hC0, {24'h0, VEC_HI});
    tally_and_finish();
  end
endmodule : flash_cmd_and_protect_test
